// [mae_pkg.sv]
// Shared constants and types for the instruction execution block
package mae_pkg;
  localparam int MAE_DW = 8;
  localparam int MAE_MEM_AW = 7;
  localparam int MAE_IMM_W = 8;
  localparam int MAE_PC_W = 10;
  localparam int MAE_REG_AW = 2;
  localparam logic [1:0] MAE_OFS_ACCUM = 2'h0;
  localparam logic [1:0] MAE_OFS_STATUS = 2'h1;
  localparam logic [1:0] MAE_OFS_PRECLR = 2'h2;
  localparam int MAE_BIT_MAIN_SPILL = 0;
  localparam int MAE_BIT_NIBBLE_CARRY = 1;
  localparam int MAE_BIT_NULL = 2;
  localparam int MAE_BIT_SIGNED_WRAP = 3;
  localparam int MAE_BIT_POWER_DOWN = 4;
  localparam int MAE_BIT_EXPIRED = 5;
  localparam int MAE_BIT_PRE_FIRST = 0;
  localparam int MAE_BIT_PRE_SECOND = 1;
  localparam logic [7:0] MAE_ACC_RST = 8'h00;
  localparam logic [3:0] MAE_FLAGS_RST = 4'h0;
  localparam logic [7:0] MAE_ZERO_BYTE = 8'h00;
  localparam logic [7:0] MAE_ONE_BYTE = 8'h01;
  localparam logic [4:0] MAE_BCD_LIMIT = 5'h09;
  localparam logic [4:0] MAE_BCD_FIX = 5'h06;

  typedef enum logic [4:0] {
    MAE_OP_NONE,
    MAE_OP_SUM_CARRY_ACC,
    MAE_OP_SUM_WITH_CARRY_TO_MEMORY,
    MAE_OP_SUM_MEM_ACC,
    MAE_OP_SUM_IMM_ACC,
    MAE_OP_SUM_TO_MEMORY,
    MAE_OP_CONJ_MEM_ACC,
    MAE_OP_CONJ_IMM_ACC,
    MAE_OP_BITWISE_CONJ_TO_MEMORY,
    MAE_OP_CALL,
    MAE_OP_BYTE_CLEAR,
    MAE_OP_BIT_CLEAR,
    MAE_OP_WATCHDOG_RESTART,
    MAE_OP_WATCHDOG_PRECLEAR_FIRST,
    MAE_OP_WATCHDOG_PRECLEAR_SECOND,
    MAE_OP_INVERT_MEMORY,
    MAE_OP_INVERT_TO_ACCUM,
    MAE_OP_BCD_ADJUST,
    MAE_OP_MINUS_ONE_MEMORY,
    MAE_OP_MINUS_ONE_TO_ACCUM
  } mae_op_t;
endpackage

// [mae_alu_core.sv]
// Combinational result and flag logic of the execution block
`timescale 1ns/1ps
module mae_alu_core
  import mae_pkg::*;
(
  input wire mae_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  input wire logic main_spill,
  input wire logic nibble_carry,
  output logic [7:0] res,
  output logic [3:0] flags,
  output logic [3:0] flags_we,
  output logic acc_we,
  output logic mem_we
);
  // Returns {spill, nibble carry, signed wrap, sum}
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    logic wrap;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    wrap = (a[7] == b[7]) && (full[7] != a[7]);
    return {full[8], lo[4], wrap, full[7:0]};
  endfunction

  logic [10:0] sum;
  logic [4:0] lo_adj;
  logic [4:0] hi_adj;
  logic adj_carry;
  logic hi_fix;

  always_comb begin
    sum = add8(acc, MAE_ZERO_BYTE, 1'b0);
    res = acc;
    flags = {1'b0, 1'b0, nibble_carry, main_spill};
    flags_we = 4'h0;
    acc_we = 1'b0;
    mem_we = 1'b0;
    lo_adj = {1'b0, acc[3:0]};
    adj_carry = 1'b0;
    hi_adj = {1'b0, acc[7:4]};
    hi_fix = 1'b0;
    unique case (op)
      MAE_OP_SUM_CARRY_ACC, MAE_OP_SUM_WITH_CARRY_TO_MEMORY, MAE_OP_SUM_MEM_ACC,
      MAE_OP_SUM_IMM_ACC, MAE_OP_SUM_TO_MEMORY: begin
        sum = add8(acc, (op == MAE_OP_SUM_IMM_ACC) ? imm : mem,
                   main_spill && (op == MAE_OP_SUM_CARRY_ACC ||
                                  op == MAE_OP_SUM_WITH_CARRY_TO_MEMORY));
        res = sum[7:0];
        flags[MAE_BIT_MAIN_SPILL] = sum[10];
        flags[MAE_BIT_NIBBLE_CARRY] = sum[9];
        flags[MAE_BIT_SIGNED_WRAP] = sum[8];
        flags_we = 4'hF;
        acc_we = (op == MAE_OP_SUM_CARRY_ACC) || (op == MAE_OP_SUM_MEM_ACC) ||
                 (op == MAE_OP_SUM_IMM_ACC);
        mem_we = !acc_we;
      end
      MAE_OP_CONJ_MEM_ACC, MAE_OP_CONJ_IMM_ACC, MAE_OP_BITWISE_CONJ_TO_MEMORY: begin
        res = acc & ((op == MAE_OP_CONJ_IMM_ACC) ? imm : mem);
        flags_we[MAE_BIT_NULL] = 1'b1;
        acc_we = (op != MAE_OP_BITWISE_CONJ_TO_MEMORY);
        mem_we = !acc_we;
      end
      MAE_OP_BYTE_CLEAR: begin
        res = MAE_ZERO_BYTE;
        mem_we = 1'b1;
      end
      MAE_OP_BIT_CLEAR: begin
        res = mem & ~(MAE_ONE_BYTE << bit_sel);
        mem_we = 1'b1;
      end
      MAE_OP_INVERT_MEMORY, MAE_OP_INVERT_TO_ACCUM: begin
        res = ~mem;
        flags_we[MAE_BIT_NULL] = 1'b1;
        acc_we = (op == MAE_OP_INVERT_TO_ACCUM);
        mem_we = !acc_we;
      end
      MAE_OP_MINUS_ONE_MEMORY, MAE_OP_MINUS_ONE_TO_ACCUM: begin
        res = mem - MAE_ONE_BYTE;
        flags_we[MAE_BIT_NULL] = 1'b1;
        acc_we = (op == MAE_OP_MINUS_ONE_TO_ACCUM);
        mem_we = !acc_we;
      end
      MAE_OP_BCD_ADJUST: begin
        if (lo_adj > MAE_BCD_LIMIT || nibble_carry) begin
          lo_adj = lo_adj + MAE_BCD_FIX;
          adj_carry = lo_adj[4];
        end
        hi_fix = (hi_adj + {4'h0, adj_carry}) > MAE_BCD_LIMIT || main_spill;
        hi_adj = hi_adj + {4'h0, adj_carry} + (hi_fix ? MAE_BCD_FIX : 5'h00);
        res = {hi_adj[3:0], lo_adj[3:0]};
        flags[MAE_BIT_MAIN_SPILL] = main_spill || hi_fix;
        flags_we[MAE_BIT_MAIN_SPILL] = 1'b1;
        mem_we = 1'b1;
      end
      default: begin
      end
    endcase
    flags[MAE_BIT_NULL] = (res == MAE_ZERO_BYTE);
  end
endmodule

// [mae_exec.sv]
// Top of the instruction execution block: state, watchdog flags, registers
`timescale 1ns/1ps
module mae_exec
  import mae_pkg::*;
#(
  parameter int MEM_AW = MAE_MEM_AW,
  parameter int PC_W = MAE_PC_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire mae_op_t op_code,
  input wire logic [MEM_AW-1:0] op_addr,
  input wire logic [MAE_IMM_W-1:0] op_imm,
  input wire logic [2:0] op_bit,
  input wire logic [PC_W-1:0] op_target,
  input wire logic [PC_W-1:0] pc_now,
  input wire logic [MAE_DW-1:0] mem_rdata,
  input wire logic watchdog_timeout,
  input wire logic halt_enter,
  input wire logic [MAE_REG_AW-1:0] reg_addr,
  input wire logic [MAE_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [MAE_DW-1:0] reg_rdata_r,
  output logic [MAE_DW-1:0] acc_r,
  output logic [3:0] arith_flags_r,
  output logic power_down_flag_r,
  output logic watchdog_expired_bit_r,
  output logic watchdog_clear_r,
  output logic mem_we_r,
  output logic [MEM_AW-1:0] mem_waddr_r,
  output logic [MAE_DW-1:0] mem_wdata_r,
  output logic stack_push_r,
  output logic [PC_W-1:0] stack_data_r,
  output logic pc_load_r,
  output logic [PC_W-1:0] pc_target_r
);
  logic [MAE_DW-1:0] alu_res;
  logic [3:0] alu_flags;
  logic [3:0] alu_flags_we;
  logic alu_acc_we;
  logic alu_mem_we;
  logic pre_first_r;
  logic pre_second_r;
  logic wdt_clear_nxt;
  logic is_pre_first;
  logic is_pre_second;

  mae_alu_core u_alu (
    .op(op_valid ? op_code : MAE_OP_NONE),
    .acc(acc_r),
    .mem(mem_rdata),
    .imm(op_imm),
    .bit_sel(op_bit),
    .main_spill(arith_flags_r[MAE_BIT_MAIN_SPILL]),
    .nibble_carry(arith_flags_r[MAE_BIT_NIBBLE_CARRY]),
    .res(alu_res),
    .flags(alu_flags),
    .flags_we(alu_flags_we),
    .acc_we(alu_acc_we),
    .mem_we(alu_mem_we)
  );

  assign is_pre_first = op_valid && op_code == MAE_OP_WATCHDOG_PRECLEAR_FIRST;
  assign is_pre_second = op_valid && op_code == MAE_OP_WATCHDOG_PRECLEAR_SECOND;
  // Counterpart must already be recorded; a repeat of the same pre-clear never clears
  assign wdt_clear_nxt = (op_valid && op_code == MAE_OP_WATCHDOG_RESTART) ||
                         (is_pre_first && pre_second_r) ||
                         (is_pre_second && pre_first_r);

  // Accumulator; an executing operation wins over a software write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= MAE_ACC_RST;
    end else if (alu_acc_we) begin
      acc_r <= alu_res;
    end else if (reg_wr && reg_addr == MAE_OFS_ACCUM) begin
      acc_r <= reg_wdata;
    end
  end

  // Arithmetic flags, per-bit enables from the datapath
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      arith_flags_r <= MAE_FLAGS_RST;
    end else if (op_valid && alu_flags_we != 4'h0) begin
      for (int i = 0; i < 4; i++) begin
        if (alu_flags_we[i]) begin
          arith_flags_r[i] <= alu_flags[i];
        end
      end
    end else if (reg_wr && reg_addr == MAE_OFS_STATUS) begin
      arith_flags_r <= reg_wdata[3:0];
    end
  end

  // Pre-clear indicators
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pre_first_r <= 1'b0;
      pre_second_r <= 1'b0;
    end else if (wdt_clear_nxt) begin
      pre_first_r <= 1'b0;
      pre_second_r <= 1'b0;
    end else begin
      if (is_pre_first) begin
        pre_first_r <= 1'b1;
      end
      if (is_pre_second) begin
        pre_second_r <= 1'b1;
      end
    end
  end

  // Status flags: a timeout or halt in the clearing cycle is kept
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      power_down_flag_r <= 1'b0;
      watchdog_expired_bit_r <= 1'b0;
      watchdog_clear_r <= 1'b0;
    end else begin
      watchdog_clear_r <= wdt_clear_nxt;
      if (halt_enter) begin
        power_down_flag_r <= 1'b1;
      end else if (wdt_clear_nxt) begin
        power_down_flag_r <= 1'b0;
      end
      if (watchdog_timeout) begin
        watchdog_expired_bit_r <= 1'b1;
      end else if (wdt_clear_nxt) begin
        watchdog_expired_bit_r <= 1'b0;
      end
    end
  end

  // Data memory write port
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_we_r <= 1'b0;
      mem_waddr_r <= '0;
      mem_wdata_r <= MAE_ZERO_BYTE;
    end else begin
      mem_we_r <= alu_mem_we;
      if (alu_mem_we) begin
        mem_waddr_r <= op_addr;
        mem_wdata_r <= alu_res;
      end
    end
  end

  // Call: push next address, load target
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stack_push_r <= 1'b0;
      pc_load_r <= 1'b0;
      stack_data_r <= '0;
      pc_target_r <= '0;
    end else begin
      stack_push_r <= op_valid && op_code == MAE_OP_CALL;
      pc_load_r <= op_valid && op_code == MAE_OP_CALL;
      if (op_valid && op_code == MAE_OP_CALL) begin
        stack_data_r <= pc_now + PC_W'(1);
        pc_target_r <= op_target;
      end
    end
  end

  // Register read port, unmapped reads return zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= MAE_ZERO_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        MAE_OFS_ACCUM: reg_rdata_r <= acc_r;
        MAE_OFS_STATUS: begin
          reg_rdata_r <= {2'b00, watchdog_expired_bit_r, power_down_flag_r, arith_flags_r};
        end
        MAE_OFS_PRECLR: reg_rdata_r <= {6'h00, pre_second_r, pre_first_r};
        default: reg_rdata_r <= MAE_ZERO_BYTE;
      endcase
    end else begin
      reg_rdata_r <= MAE_ZERO_BYTE;
    end
  end

  sequence s_pre_first;
    op_valid && op_code == MAE_OP_WATCHDOG_PRECLEAR_FIRST && !watchdog_timeout && !halt_enter;
  endsequence
  sequence s_pre_second;
    op_valid && op_code == MAE_OP_WATCHDOG_PRECLEAR_SECOND && !watchdog_timeout && !halt_enter;
  endsequence

  AST_SUM_IMM: assert property (@(posedge clk_sys) disable iff (!rst_b)
    op_valid && op_code == MAE_OP_SUM_IMM_ACC |=>
      acc_r == 8'($past(acc_r) + $past(op_imm)))
    else $error("Immediate sum wrong");
  AST_CARRY_IN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    op_valid && op_code == MAE_OP_SUM_CARRY_ACC |=>
      {arith_flags_r[MAE_BIT_MAIN_SPILL], acc_r} ==
      9'({1'b0, $past(acc_r)} + {1'b0, $past(mem_rdata)} +
         {8'h00, $past(arith_flags_r[MAE_BIT_MAIN_SPILL])}))
    else $error("Carry sum wrong");
  AST_CONJ_MEM: assert property (@(posedge clk_sys) disable iff (!rst_b)
    op_valid && op_code == MAE_OP_BITWISE_CONJ_TO_MEMORY |=>
      mem_we_r && mem_wdata_r == ($past(acc_r) & $past(mem_rdata)) &&
      arith_flags_r[MAE_BIT_MAIN_SPILL] == $past(arith_flags_r[MAE_BIT_MAIN_SPILL]))
    else $error("Memory AND wrong");
  AST_CALL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    op_valid && op_code == MAE_OP_CALL |=>
      stack_push_r && pc_load_r && stack_data_r == PC_W'($past(pc_now) + 1) &&
      $stable(arith_flags_r) ##1 !stack_push_r || $past(op_valid))
    else $error("Call wrong");
  AST_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_b)
    op_valid && op_code == MAE_OP_WATCHDOG_RESTART && !halt_enter && !watchdog_timeout |=>
      watchdog_clear_r && !power_down_flag_r && !watchdog_expired_bit_r)
    else $error("Restart did not clear");
  AST_PRE_PAIR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_pre_second ##0 pre_first_r |=>
      watchdog_clear_r && !watchdog_expired_bit_r && !power_down_flag_r)
    else $error("Pre-clear pair did not clear");
  AST_PRE_LONE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_pre_first ##0 !pre_second_r |=>
      !watchdog_clear_r && pre_first_r && $stable(power_down_flag_r) &&
      $stable(watchdog_expired_bit_r))
    else $error("Lone pre-clear changed flags");
  AST_INVERT_ACC: assert property (@(posedge clk_sys) disable iff (!rst_b)
    op_valid && op_code == MAE_OP_INVERT_TO_ACCUM |=>
      acc_r == ~$past(mem_rdata) && !mem_we_r &&
      arith_flags_r[MAE_BIT_NULL] == (acc_r == MAE_ZERO_BYTE))
    else $error("Invert to accumulator wrong");
  AST_BIT_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    op_valid && op_code == MAE_OP_BIT_CLEAR |=>
      mem_we_r && mem_wdata_r[$past(op_bit)] == 1'b0 &&
      (mem_wdata_r | (MAE_ONE_BYTE << $past(op_bit))) ==
      ($past(mem_rdata) | (MAE_ONE_BYTE << $past(op_bit))))
    else $error("Bit clear wrong");
  AST_MINUS_MEM: assert property (@(posedge clk_sys) disable iff (!rst_b)
    op_valid && op_code == MAE_OP_MINUS_ONE_MEMORY |=>
      mem_we_r && mem_wdata_r == 8'($past(mem_rdata) - 1) && $stable(acc_r))
    else $error("Memory decrement wrong");
  AST_BCD_SPILL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    op_valid && op_code == MAE_OP_BCD_ADJUST && arith_flags_r[MAE_BIT_MAIN_SPILL] |=>
      arith_flags_r[MAE_BIT_MAIN_SPILL] && mem_we_r &&
      mem_wdata_r[7:4] == 4'($past(acc_r[7:4]) + 4'h6 + {3'h0, $past(alu_res[3:0]) <
                                                         $past(acc_r[3:0])}))
    else $error("Decimal adjust high nibble wrong");
endmodule

// [mae_mem_model.sv]
// Data memory model standing behind the execution block
`timescale 1ns/1ps
module mae_mem_model
  import mae_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [MAE_MEM_AW-1:0] rd_addr,
  input wire logic we,
  input wire logic [MAE_MEM_AW-1:0] waddr,
  input wire logic [MAE_DW-1:0] wdata,
  output logic [MAE_DW-1:0] rdata
);
  logic [MAE_DW-1:0] mem_q [0:(1<<MAE_MEM_AW)-1];

  // Combinational read, the byte is needed in the op cycle
  assign rdata = mem_q[rd_addr];

  // Write lands one edge after the pulse; no forwarding to a following op
  always @(posedge clk_sys) begin
    if (we === 1'b1) begin
      mem_q[waddr] <= wdata;
    end
  end
endmodule

// [tb_top.sv]
// Self-checking bench for the instruction execution block
`timescale 1ns/1ps
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (act), (exp)); end end
module tb_top;
  import mae_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic op_valid = 1'b0;
  mae_op_t op_code = MAE_OP_NONE;
  logic [6:0] op_addr = 7'h00;
  logic [7:0] op_imm = 8'h00;
  logic [2:0] op_bit = 3'h0;
  // Top of program space, so the pushed return address wraps
  logic [9:0] op_target = 10'h2AB;
  logic [9:0] pc_now = 10'h3FF;
  logic [7:0] mem_rdata;
  logic watchdog_timeout = 1'b0;
  logic halt_enter = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata_r, acc_r, mem_wdata_r;
  logic [3:0] arith_flags_r;
  logic power_down_flag_r, watchdog_expired_bit_r, watchdog_clear_r, mem_we_r;
  logic [6:0] mem_waddr_r;
  logic stack_push_r, pc_load_r;
  logic [9:0] stack_data_r, pc_target_r;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] e_acc = 8'h00;
  logic [3:0] e_flg = 4'h0;
  logic [1:0] e_ind = 2'b00;
  logic e_pd = 1'b0;
  logic e_to = 1'b0;
  logic [7:0] e_mem [0:127];
  logic [7:0] bcd_acc [4] = '{8'h9A, 8'h19, 8'h45, 8'h99};
  logic [3:0] bcd_flg [4] = '{4'hC, 4'h2, 4'h1, 4'h4};

  always #4 clk_sys = ~clk_sys;

  mae_exec dut (.clk_sys(clk_sys), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_imm(op_imm), .op_bit(op_bit), .op_target(op_target),
    .pc_now(pc_now), .mem_rdata(mem_rdata), .watchdog_timeout(watchdog_timeout),
    .halt_enter(halt_enter), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .acc_r(acc_r), .arith_flags_r(arith_flags_r),
    .power_down_flag_r(power_down_flag_r), .watchdog_expired_bit_r(watchdog_expired_bit_r),
    .watchdog_clear_r(watchdog_clear_r), .mem_we_r(mem_we_r), .mem_waddr_r(mem_waddr_r),
    .mem_wdata_r(mem_wdata_r), .stack_push_r(stack_push_r), .stack_data_r(stack_data_r),
    .pc_load_r(pc_load_r), .pc_target_r(pc_target_r));

  mae_mem_model mem_model (.clk_sys(clk_sys), .rd_addr(op_addr), .we(mem_we_r),
    .waddr(mem_waddr_r), .wdata(mem_wdata_r), .rdata(mem_rdata));

  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run is about two hundred cycles; this only catches a hang
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic put(input logic [6:0] a, input logic [7:0] v);
    e_mem[a] = v;
    mem_model.mem_q[a] = v;
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata_r, e)
    @(posedge clk_sys);
    #1;
    `CHK(reg_rdata_r, 8'h00)
  endtask

  task automatic setup(input logic [7:0] a, input logic [3:0] f);
    reg_write(2'h0, a);
    reg_write(2'h1, {4'h0, f});
    e_acc = a;
    e_flg = f;
  endtask

  task automatic wd_status();
    reg_check(2'h1, {2'b00, e_to, e_pd, e_flg});
    reg_check(2'h2, {6'h00, e_ind});
  endtask

  // Sets both levels, then tries to clear them through the status write
  task automatic pulse();
    @(posedge clk_sys);
    halt_enter <= 1'b1;
    watchdog_timeout <= 1'b1;
    @(posedge clk_sys);
    halt_enter <= 1'b0;
    watchdog_timeout <= 1'b0;
    e_pd = 1'b1;
    e_to = 1'b1;
    reg_write(2'h1, 8'h00);
    e_flg = 4'h0;
    wd_status();
  endtask

  task automatic exec(input mae_op_t c, input logic [6:0] a, input logic [7:0] x,
                      input logic [2:0] b);
    logic [7:0] m;
    logic [7:0] r;
    logic [8:0] s;
    logic [4:0] lo;
    logic [4:0] hi;
    logic wm;
    logic zf;
    logic cin;
    logic clr;
    m = (c == MAE_OP_SUM_IMM_ACC || c == MAE_OP_CONJ_IMM_ACC) ? x : e_mem[a];
    zf = 1'b1;
    clr = 1'b0;
    r = 8'h00;
    cin = (c == MAE_OP_SUM_CARRY_ACC || c == MAE_OP_SUM_WITH_CARRY_TO_MEMORY) & e_flg[0];
    s = {1'b0, e_acc} + {1'b0, m} + {8'h00, cin};
    lo = {1'b0, e_acc[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
    wm = c inside {MAE_OP_SUM_WITH_CARRY_TO_MEMORY, MAE_OP_SUM_TO_MEMORY, MAE_OP_BYTE_CLEAR,
      MAE_OP_BITWISE_CONJ_TO_MEMORY, MAE_OP_INVERT_MEMORY, MAE_OP_MINUS_ONE_MEMORY,
      MAE_OP_BIT_CLEAR, MAE_OP_BCD_ADJUST};
    case (c)
      MAE_OP_SUM_CARRY_ACC, MAE_OP_SUM_MEM_ACC, MAE_OP_SUM_IMM_ACC,
      MAE_OP_SUM_WITH_CARRY_TO_MEMORY, MAE_OP_SUM_TO_MEMORY: begin
        r = s[7:0];
        e_flg[1:0] = {lo[4], s[8]};
        e_flg[3] = (e_acc[7] == m[7]) && (r[7] != e_acc[7]);
      end
      MAE_OP_CONJ_MEM_ACC, MAE_OP_CONJ_IMM_ACC, MAE_OP_BITWISE_CONJ_TO_MEMORY: r = e_acc & m;
      MAE_OP_INVERT_MEMORY, MAE_OP_INVERT_TO_ACCUM: r = ~m;
      MAE_OP_MINUS_ONE_MEMORY, MAE_OP_MINUS_ONE_TO_ACCUM: r = m - 8'h01;
      default: zf = 1'b0;
    endcase
    case (c)
      MAE_OP_BIT_CLEAR: r = m & ~(8'h01 << b);
      MAE_OP_BCD_ADJUST: begin
        lo = {1'b0, e_acc[3:0]};
        if (lo > 5'h09 || e_flg[1]) lo = lo + 5'h06;
        hi = {1'b0, e_acc[7:4]} + {4'h0, lo[4]};
        if (hi > 5'h09 || e_flg[0]) begin
          hi = hi + 5'h06;
          e_flg[0] = 1'b1;
        end
        r = {hi[3:0], lo[3:0]};
      end
      MAE_OP_WATCHDOG_RESTART: clr = 1'b1;
      MAE_OP_WATCHDOG_PRECLEAR_FIRST: begin
        clr = e_ind[1];
        e_ind[0] = 1'b1;
      end
      MAE_OP_WATCHDOG_PRECLEAR_SECOND: begin
        clr = e_ind[0];
        e_ind[1] = 1'b1;
      end
      default: ;
    endcase
    if (zf) e_flg[2] = (r == 8'h00);
    if (zf && !wm) e_acc = r;
    if (wm) e_mem[a] = r;
    if (clr) begin
      e_ind = 2'b00;
      e_pd = 1'b0;
      e_to = 1'b0;
    end
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code <= c;
    op_addr <= a;
    op_imm <= x;
    op_bit <= b;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    `CHK(acc_r, e_acc)
    `CHK(arith_flags_r, e_flg)
    `CHK(mem_we_r, wm)
    if (wm) `CHK({mem_waddr_r, mem_wdata_r}, {a, r})
    `CHK({stack_push_r, pc_load_r}, {2{c == MAE_OP_CALL}})
    if (c == MAE_OP_CALL) `CHK({stack_data_r, pc_target_r}, {10'h000, 10'h2AB})
    `CHK(watchdog_clear_r, clr)
  endtask

  task automatic wd(input mae_op_t c);
    exec(c, 7'h00, 8'h00, 3'h0);
    wd_status();
  endtask

  initial begin
    for (int i = 0; i < 128; i++) begin
      put(7'(i), 8'(i * 37));
    end
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    reg_write(2'h3, 8'hFF);
    reg_write(2'h2, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      reg_check(2'(i), 8'h00);
    end
    reg_write(2'h1, 8'hFF);
    e_flg = 4'hF;
    wd_status();
    setup(8'h7F, 4'h1);
    put(7'h05, 8'h80);
    exec(MAE_OP_SUM_CARRY_ACC, 7'h05, 8'h00, 3'h0);
    exec(MAE_OP_SUM_IMM_ACC, 7'h00, 8'hFF, 3'h0);
    setup(8'hFF, 4'h1);
    put(7'h08, 8'h01);
    exec(MAE_OP_SUM_MEM_ACC, 7'h08, 8'h00, 3'h0);
    setup(8'h40, 4'h1);
    put(7'h06, 8'h40);
    exec(MAE_OP_SUM_WITH_CARRY_TO_MEMORY, 7'h06, 8'h00, 3'h0);
    setup(8'h40, 4'h1);
    put(7'h09, 8'hC0);
    exec(MAE_OP_SUM_TO_MEMORY, 7'h09, 8'h00, 3'h0);
    setup(8'hF3, 4'hB);
    put(7'h0A, 8'h0C);
    exec(MAE_OP_CONJ_MEM_ACC, 7'h0A, 8'h00, 3'h0);
    setup(8'hF3, 4'h0);
    exec(MAE_OP_CONJ_IMM_ACC, 7'h00, 8'h3C, 3'h0);
    exec(MAE_OP_BITWISE_CONJ_TO_MEMORY, 7'h0A, 8'h00, 3'h0);
    setup(8'h12, 4'hB);
    exec(MAE_OP_BYTE_CLEAR, 7'h0B, 8'h00, 3'h0);
    put(7'h0C, 8'hFF);
    exec(MAE_OP_BIT_CLEAR, 7'h0C, 8'h00, 3'h7);
    put(7'h0D, 8'h01);
    exec(MAE_OP_BIT_CLEAR, 7'h0D, 8'h00, 3'h0);
    put(7'h0E, 8'hFF);
    exec(MAE_OP_INVERT_MEMORY, 7'h0E, 8'h00, 3'h0);
    put(7'h0F, 8'h5A);
    exec(MAE_OP_INVERT_TO_ACCUM, 7'h0F, 8'h00, 3'h0);
    put(7'h10, 8'h00);
    exec(MAE_OP_MINUS_ONE_MEMORY, 7'h10, 8'h00, 3'h0);
    put(7'h11, 8'h01);
    exec(MAE_OP_MINUS_ONE_MEMORY, 7'h11, 8'h00, 3'h0);
    exec(MAE_OP_MINUS_ONE_TO_ACCUM, 7'h11, 8'h00, 3'h0);
    exec(MAE_OP_CALL, 7'h00, 8'h00, 3'h0);
    for (int i = 0; i < 4; i++) begin
      setup(bcd_acc[i], bcd_flg[i]);
      exec(MAE_OP_BCD_ADJUST, 7'h14, 8'h00, 3'h0);
    end
    pulse();
    wd(MAE_OP_WATCHDOG_RESTART);
    pulse();
    wd(MAE_OP_WATCHDOG_PRECLEAR_FIRST);
    wd(MAE_OP_WATCHDOG_PRECLEAR_FIRST);
    wd(MAE_OP_WATCHDOG_PRECLEAR_SECOND);
    pulse();
    wd(MAE_OP_WATCHDOG_PRECLEAR_SECOND);
    wd(MAE_OP_WATCHDOG_PRECLEAR_FIRST);
    finish_test();
  end
endmodule
